// ==== ppp_device.sv ====
/*
  device end: command/address/data latches, memories, fuses, lock
  bits and self-timed busy. assumes pins synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - action select picks address, data, command, idle
// - load strobe rising edge captures bus byte
// - command and address kept between operations
// - eeprom bytes buffered, latched page bytes programmed
// - host sequences eeprom page load steps
// - program pulse starts page write, busy
// - host loads flash read command and address
// - flash read: select A picks byte
// - eeprom read drives addressed byte
// - fuse low write: zero programs, one erases
// - select A high with select B low writes fuse high
// - select B high with select A low writes extended fuse
// - lock write: zero bit programs lock
// - mode three blocks boot lock programming
// - lock bits cleared only by erase; nrst here also reloads lock_ff to LOCK_RST
// - fuse/lock readback chosen by selects
// - signature byte by low address
// - calibration byte with select A high
// - data bus released after enable high
// - busy within one microsecond of pulse
// - write busy between 3.7 and 4.5 ms
// - erase busy between 7.5 and 9 ms
module ppp_device
  import ppp_pkg::*;
#(
  parameter int WR_BUSY_CYC = WR_MIN_CYC,
  parameter int CE_BUSY_CYC = CE_MIN_CYC,
  parameter logic [7:0] SIG0 = 8'h5A, // arbitrary value
  parameter logic [7:0] SIG1 = 8'h3C, // arbitrary value
  parameter logic [7:0] SIG2 = 8'h21, // arbitrary value
  parameter logic [7:0] CALIB = 8'h80, // arbitrary value
  parameter logic [7:0] FUSE_LO_RST = 8'hE2,
  parameter logic [7:0] FUSE_HI_RST = 8'hDF,
  parameter logic [7:0] FUSE_EX_RST = 8'hF9
) (
  input wire logic clock,
  input wire logic nrst,
  ppp_if.device pins
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] flashLo [FLASH_WORDS];
  logic [7:0] flashHi [FLASH_WORDS];
  logic [7:0] eeMem [EE_BYTES];
  logic [7:0] pageBuf_ff [EE_PAGE];
  logic [EE_PAGE-1:0] pageMask_ff;
  logic [7:0] cmd_ff, addrLo_ff, addrHi_ff, dataLo_ff, dataHi_ff;
  logic [7:0] fuseLo_ff, fuseHi_ff, fuseEx_ff, lock_ff;
  logic strobePrev_ff, latchPrev_ff, progPrev_ff;
  logic busy_ff, erasing_ff;
  logic [BUSY_W-1:0] busyCnt_ff;
  logic [FLASH_AW-1:0] eraseIdx_ff;
  logic [7:0] dout_ff;
  logic doe_ff;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire loadRise = pins.loadStrobeClock & ~strobePrev_ff;
  wire latchRise = pins.pageLatchStrobe & ~latchPrev_ff;
  wire progFall = ~pins.progPulseN & progPrev_ff;
  wire accept = ~busy_ff;
  wire doLoad = loadRise & accept;
  wire doProg = progFall & accept;
  wire [FLASH_AW-1:0] flashAddr = {addrHi_ff[4:0], addrLo_ff};
  wire [EE_AW-1:0] eeAddr = {addrHi_ff[0], addrLo_ff};
  wire isWrite = (cmd_ff == CMD_WR_FUSE) || (cmd_ff == CMD_WR_LOCK) ||
                 (cmd_ff == CMD_WR_FLASH) || (cmd_ff == CMD_WR_EE);
  wire isErase = cmd_ff == CMD_ERASE;
  wire startBusy = doProg & (isWrite | isErase);
  wire selFuseHi = pins.byteSelectA & ~pins.byteSelectB;
  wire selFuseEx = ~pins.byteSelectA & pins.byteSelectB;
  wire lockMode3 = lock_ff[LOCK_MAIN_LSB+1:LOCK_MAIN_LSB] == 2'h0;
  wire [7:0] lockKeep = lockMode3 ?
    8'((1 << (LOCK_BOOT_MSB + 1)) - (1 << LOCK_BOOT_LSB)) : 8'h00;
  // 0 bits only accumulate; boot bits frozen in mode 3
  wire [7:0] lockNext = lock_ff & (dataLo_ff | lockKeep);
  wire [BUSY_W-1:0] wrCnt = BUSY_W'(WR_BUSY_CYC);
  wire [BUSY_W-1:0] ceCnt = BUSY_W'(CE_BUSY_CYC);
  wire eraseLast = eraseIdx_ff == FLASH_AW'(FLASH_WORDS - 1);
  logic [7:0] rdMux;
  logic rdValid;
  // ----------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------
  always_comb begin
    rdMux = ERASED;
    rdValid = 1'b1;
    case (cmd_ff)
      CMD_RD_FLASH: rdMux = pins.byteSelectA ? flashHi[flashAddr] :
                                               flashLo[flashAddr];
      CMD_RD_EE: begin
        rdMux = eeMem[eeAddr];
        rdValid = ~pins.byteSelectA;
      end
      CMD_RD_FUSE: begin
        case ({pins.byteSelectB, pins.byteSelectA})
          2'h0: rdMux = fuseLo_ff;
          2'h3: rdMux = fuseHi_ff;
          2'h2: rdMux = fuseEx_ff;
          default: rdMux = lock_ff;
        endcase
      end
      CMD_RD_SIG: begin
        if (pins.byteSelectA) begin
          rdMux = CALIB;
          rdValid = addrLo_ff == 8'h00;
        end else begin
          rdValid = addrLo_ff <= 8'h02;
          case (addrLo_ff[1:0])
            2'h0: rdMux = SIG0;
            2'h1: rdMux = SIG1;
            default: rdMux = SIG2;
          endcase
        end
      end
      default: rdValid = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // edge history and byte latches
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strobePrev_ff <= 1'b0;
      latchPrev_ff <= 1'b0;
      progPrev_ff <= 1'b1;
    end else begin
      strobePrev_ff <= pins.loadStrobeClock;
      latchPrev_ff <= pins.pageLatchStrobe;
      progPrev_ff <= pins.progPulseN;
    end
  end
  // held until overwritten by a later load
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_ff <= 8'h00;
      addrLo_ff <= 8'h00;
      addrHi_ff <= 8'h00;
      dataLo_ff <= 8'hFF;
      dataHi_ff <= 8'hFF;
    end else if (doLoad) begin
      case (pins.actionSelect)
        ACT_ADDR: begin
          if (pins.byteSelectA) addrHi_ff <= pins.dataBus;
          else addrLo_ff <= pins.dataBus;
        end
        ACT_DATA: begin
          if (pins.byteSelectA) dataHi_ff <= pins.dataBus;
          else dataLo_ff <= pins.dataBus;
        end
        ACT_CMD: cmd_ff <= pins.dataBus;
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // eeprom page buffer
  // ----------------------------------------------------------------
  for (genvar i = 0; i < EE_PAGE; i++) begin : g_page
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        pageBuf_ff[i] <= ERASED;
        pageMask_ff[i] <= 1'b0;
      end else if (startBusy && cmd_ff == CMD_WR_EE) begin
        pageMask_ff[i] <= 1'b0;
      end else if (latchRise && accept && cmd_ff == CMD_WR_EE &&
                   addrLo_ff[1:0] == 2'(i)) begin
        pageBuf_ff[i] <= dataLo_ff;
        pageMask_ff[i] <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // memory arrays: page program, word write, erase walk
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (erasing_ff) begin
      flashLo[eraseIdx_ff] <= ERASED;
      flashHi[eraseIdx_ff] <= ERASED;
      eeMem[eraseIdx_ff[EE_AW-1:0]] <= ERASED;
    end else if (startBusy && cmd_ff == CMD_WR_EE) begin
      for (int j = 0; j < EE_PAGE; j++) begin
        if (pageMask_ff[j])
          eeMem[{eeAddr[EE_AW-1:2], 2'(j)}] <= pageBuf_ff[j];
      end
    end else if (startBusy && cmd_ff == CMD_WR_FLASH) begin
      flashLo[flashAddr] <= dataLo_ff;
      flashHi[flashAddr] <= dataHi_ff;
    end
  end
  // ----------------------------------------------------------------
  // fuses and lock bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fuseLo_ff <= FUSE_LO_RST;
      fuseHi_ff <= FUSE_HI_RST;
      fuseEx_ff <= FUSE_EX_RST;
      lock_ff <= LOCK_RST;
    end else if (erasing_ff && eraseLast) begin
      lock_ff <= LOCK_RST;
    end else if (startBusy && cmd_ff == CMD_WR_FUSE) begin
      if (selFuseHi) fuseHi_ff <= dataLo_ff;
      else if (selFuseEx) fuseEx_ff <= dataLo_ff;
      else fuseLo_ff <= dataLo_ff;
    end else if (startBusy && cmd_ff == CMD_WR_LOCK) begin
      lock_ff <= lockNext;
    end
  end
  // ----------------------------------------------------------------
  // busy timer and erase walker
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
      busyCnt_ff <= '0;
      erasing_ff <= 1'b0;
      eraseIdx_ff <= '0;
    end else if (startBusy) begin
      busy_ff <= 1'b1;
      busyCnt_ff <= isErase ? ceCnt - 1'b1 : wrCnt - 1'b1;
      erasing_ff <= isErase;
      eraseIdx_ff <= '0;
    end else if (busy_ff) begin
      if (busyCnt_ff != '0) busyCnt_ff <= busyCnt_ff - 1'b1;
      if (erasing_ff) begin
        eraseIdx_ff <= eraseIdx_ff + 1'b1;
        if (eraseLast) erasing_ff <= 1'b0;
      end
      if (busyCnt_ff == '0 && !erasing_ff) busy_ff <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dout_ff <= 8'h00;
      doe_ff <= 1'b0;
    end else begin
      dout_ff <= rdMux;
      doe_ff <= ~pins.outputEnableN & rdValid & accept;
    end
  end
  assign pins.devDataOut = dout_ff;
  assign pins.devDataOe = doe_ff;
  assign pins.readyBusyFlag = ~busy_ff;
endmodule : ppp_device
`default_nettype wire

// ==== ppp_pkg.sv ====
/*
  constants shared by both ends of the parallel programming port.
  assumes a 10 MHz system clock on both ends.
*/
package ppp_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int T_WLRL_MAX_NS = 1000;
  localparam int T_WR_MIN_US = 3700;
  localparam int T_WR_MAX_US = 4500;
  localparam int T_CE_MIN_US = 7500;
  localparam int T_CE_MAX_US = 9000;
  localparam int T_DVXH_NS = 67;
  localparam int T_XHXL_NS = 150;
  localparam int T_XLDX_NS = 67;
  localparam int T_OLDV_NS = 250;
  localparam int T_OHDZ_NS = 250;
  localparam int WR_MIN_CYC = (T_WR_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WR_MAX_CYC = T_WR_MAX_US * 1000 / CLK_NS;
  localparam int CE_MIN_CYC = (T_CE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CE_MAX_CYC = T_CE_MAX_US * 1000 / CLK_NS;
  localparam int WLRL_MAX_CYC = T_WLRL_MAX_NS / CLK_NS;
  localparam int SETUP_CYC = (T_DVXH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_XHXL_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_XLDX_NS + CLK_NS - 1) / CLK_NS;
  localparam int OLDV_CYC = (T_OLDV_NS + CLK_NS - 1) / CLK_NS;
  localparam int OHDZ_CYC = (T_OHDZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_W = 17;
  // ----------------------------------------------------------------
  // action select and commands
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  // ----------------------------------------------------------------
  // memory geometry and reset values
  // ----------------------------------------------------------------
  localparam int FLASH_WORDS = 8192;
  localparam int FLASH_AW = 13;
  localparam int EE_BYTES = 512;
  localparam int EE_AW = 9;
  localparam int EE_PAGE = 4;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam int LOCK_MAIN_LSB = 0;
  localparam int LOCK_BOOT_LSB = 2;
  localparam int LOCK_BOOT_MSB = 5;
  // ----------------------------------------------------------------
  // host register map and fields
  // ----------------------------------------------------------------
  localparam logic [1:0] HREG_PINS = 2'h0;
  localparam logic [1:0] HREG_GO = 2'h1;
  localparam logic [1:0] HREG_STAT = 2'h2;
  localparam logic [1:0] HREG_RDATA = 2'h3;
  localparam int PIN_ACT_LSB = 8;
  localparam int PIN_BSA = 10;
  localparam int PIN_BSB = 11;
  localparam logic [1:0] OP_LOAD = 2'h0;
  localparam logic [1:0] OP_LATCH = 2'h1;
  localparam logic [1:0] OP_PROG = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  typedef enum logic [2:0] {
    HS_IDLE, HS_SETUP, HS_PULSE, HS_HOLD, HS_RDWAIT, HS_TURN
  } ppp_hstate_t;
endpackage : ppp_pkg

// ==== ppp_if.sv ====
/*
  pin bundle between programmer and device.
  assumes both ends share one clock; resolves the data bus from enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface ppp_if;
  logic [1:0] actionSelect;
  logic byteSelectA;
  logic byteSelectB;
  logic loadStrobeClock;
  logic pageLatchStrobe;
  logic progPulseN;
  logic outputEnableN;
  logic readyBusyFlag;
  logic [7:0] hostDataOut;
  logic hostDataOe;
  logic [7:0] devDataOut;
  logic devDataOe;
  logic [7:0] dataBus;
  // ----------------------------------------------------------------
  // bus resolution, undriven bus reads high
  // ----------------------------------------------------------------
  assign dataBus = hostDataOe ? hostDataOut :
                   devDataOe ? devDataOut : 8'hFF;
  modport device (
    input actionSelect, byteSelectA, byteSelectB, loadStrobeClock,
    input pageLatchStrobe, progPulseN, outputEnableN, dataBus,
    output readyBusyFlag, devDataOut, devDataOe
  );
  modport host (
    output actionSelect, byteSelectA, byteSelectB, loadStrobeClock,
    output pageLatchStrobe, progPulseN, outputEnableN,
    output hostDataOut, hostDataOe,
    input readyBusyFlag, dataBus
  );
endinterface : ppp_if
`default_nettype wire

// ==== ppp_host.sv ====
/*
  programmer end: software sets pin levels and fires one pin action
  at a time; read data captured for software. assumes one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ppp_host
  import ppp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  ppp_if.host pins
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [11:0] pinReg_ff;
  logic [1:0] op_ff;
  ppp_hstate_t st_ff, nxt_st;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [7:0] rdByte_ff;
  logic refused_ff;
  logic [15:0] rdata_ff;
  logic strobe_ff, latch_ff, progN_ff, oeN_ff, drive_ff;
  wire idle = st_ff == HS_IDLE;
  wire goWr = regWr && regAddr == HREG_GO;
  wire [1:0] goOp = regWdata[1:0];
  // device busy blocks all but reads
  wire goOk = idle && (pins.readyBusyFlag || goOp == OP_READ);
  wire reading = st_ff == HS_RDWAIT;
  logic [15:0] rdMux;
  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (regAddr)
      HREG_PINS: rdMux = {4'h0, pinReg_ff};
      HREG_STAT: rdMux = {13'h0000, refused_ff, pins.readyBusyFlag, ~idle};
      HREG_RDATA: rdMux = {8'h00, rdByte_ff};
      default: rdMux = 16'h0000;
    endcase
  end
  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      HS_IDLE: begin
        if (goWr && goOk) begin
          nxt_st = goOp == OP_READ ? HS_RDWAIT : HS_SETUP;
          nxt_cnt = goOp == OP_READ ? 2'(OLDV_CYC - 1) : 2'(SETUP_CYC - 1);
        end
      end
      HS_SETUP: if (cnt_ff == 2'h0) begin
        nxt_st = HS_PULSE;
        nxt_cnt = 2'(PULSE_CYC - 1);
      end else nxt_cnt = cnt_ff - 1'b1;
      HS_PULSE: if (cnt_ff == 2'h0) begin
        nxt_st = HS_HOLD;
        nxt_cnt = 2'(HOLD_CYC - 1);
      end else nxt_cnt = cnt_ff - 1'b1;
      HS_RDWAIT: if (cnt_ff == 2'h0) begin
        nxt_st = HS_TURN;
        nxt_cnt = 2'(OHDZ_CYC - 1);
      end else nxt_cnt = cnt_ff - 1'b1;
      HS_HOLD, HS_TURN: if (cnt_ff == 2'h0) nxt_st = HS_IDLE;
        else nxt_cnt = cnt_ff - 1'b1;
      default: nxt_st = HS_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= HS_IDLE;
      cnt_ff <= 2'h0;
      op_ff <= OP_LOAD;
      pinReg_ff <= {2'h0, ACT_IDLE, 8'h00};
      refused_ff <= 1'b0;
      rdByte_ff <= 8'h00;
      rdata_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      rdata_ff <= regRd ? rdMux : 16'h0000;
      if (goWr && goOk) op_ff <= goOp;
      if (goWr) refused_ff <= ~goOk;
      if (regWr && regAddr == HREG_PINS) pinReg_ff <= regWdata[11:0];
      if (reading && cnt_ff == 2'h0) rdByte_ff <= pins.dataBus;
    end
  end
  // ----------------------------------------------------------------
  // pin flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strobe_ff <= 1'b0;
      latch_ff <= 1'b0;
      progN_ff <= 1'b1;
      oeN_ff <= 1'b1;
      drive_ff <= 1'b0;
    end else begin
      strobe_ff <= nxt_st == HS_PULSE && op_ff == OP_LOAD && !idle;
      latch_ff <= nxt_st == HS_PULSE && op_ff == OP_LATCH && !idle;
      progN_ff <= ~(nxt_st == HS_PULSE && op_ff == OP_PROG && !idle);
      oeN_ff <= ~(nxt_st == HS_RDWAIT);
      drive_ff <= nxt_st != HS_RDWAIT && nxt_st != HS_TURN;
    end
  end
  assign pins.actionSelect = pinReg_ff[PIN_ACT_LSB+1:PIN_ACT_LSB];
  assign pins.byteSelectA = pinReg_ff[PIN_BSA];
  assign pins.byteSelectB = pinReg_ff[PIN_BSB];
  assign pins.hostDataOut = pinReg_ff[7:0];
  assign pins.hostDataOe = drive_ff;
  assign pins.loadStrobeClock = strobe_ff;
  assign pins.pageLatchStrobe = latch_ff;
  assign pins.progPulseN = progN_ff;
  assign pins.outputEnableN = oeN_ff;
  assign regRdata = rdata_ff;
endmodule : ppp_host
`default_nettype wire

// ==== ppp_props.sv ====
/* checker: pin timing and bus ownership of the programming port.
   assumes one clock, reset active low, placed beside ppp_if. */
`timescale 1ns/1ps
`default_nettype none
module ppp_props
  import ppp_pkg::*;
#(
  parameter int WR_BUSY_CYC = WR_MIN_CYC,
  parameter int CE_BUSY_CYC = CE_MIN_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] actionSelect,
  input wire logic byteSelectA,
  input wire logic loadStrobeClock,
  input wire logic progPulseN,
  input wire logic outputEnableN,
  input wire logic readyBusyFlag,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  input wire logic [7:0] dataBus
);
  localparam int CE_LEN = (CE_BUSY_CYC > FLASH_WORDS + 1) ? CE_BUSY_CYC :
    FLASH_WORDS + 1;
  logic [7:0] cmdSeen_ff;
  logic [7:0] addrLo_ff;
  logic [16:0] busyCnt_ff;
  // ------------------------------------------------------------
  // last command, low address, busy length
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmdSeen_ff <= 8'h00;
      addrLo_ff <= 8'h00;
      busyCnt_ff <= 17'h00000;
    end else begin
      if ($rose(loadStrobeClock) && readyBusyFlag) begin
        if (actionSelect == ACT_CMD) cmdSeen_ff <= dataBus;
        if (actionSelect == ACT_ADDR && !byteSelectA) addrLo_ff <= dataBus;
      end
      if ($fell(progPulseN)) busyCnt_ff <= 17'h00000;
      else if (!readyBusyFlag) busyCnt_ff <= busyCnt_ff + 17'h00001;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  busy_fall_a:
    assert property ($fell(progPulseN) && readyBusyFlag |-> ##[1:10]
      !readyBusyFlag) else $error("busy late after program pulse");
  busy_hold_a:
    assert property ($fell(readyBusyFlag) |=> !readyBusyFlag [*8])
      else $error("busy ended too soon");
  write_busy_len_a:
    assert property ($rose(readyBusyFlag) && cmdSeen_ff != CMD_ERASE |->
      busyCnt_ff >= WR_BUSY_CYC && busyCnt_ff <= WR_BUSY_CYC + 1)
      else $error("write busy length wrong");
  erase_busy_len_a:
    assert property ($rose(readyBusyFlag) && cmdSeen_ff == CMD_ERASE |->
      busyCnt_ff >= CE_LEN && busyCnt_ff <= CE_LEN + 1)
      else $error("erase busy length wrong");
  bus_release_a:
    assert property ($rose(outputEnableN) |-> ##[1:3] !devDataOe)
      else $error("data bus not released");
  drive_needs_oe_a:
    assert property ($rose(devDataOe) |-> $past(outputEnableN) == 1'b0)
      else $error("bus driven without output enable");
  no_drive_busy_a:
    assert property (!readyBusyFlag |-> !devDataOe)
      else $error("bus driven while busy");
  no_clash_a:
    assert property (!(devDataOe && hostDataOe))
      else $error("both ends drive the bus");
  sig_range_a:
    assert property (devDataOe && cmdSeen_ff == CMD_RD_SIG |->
      ($past(byteSelectA) ? addrLo_ff == 8'h00 : addrLo_ff <= 8'h02))
      else $error("signature driven at bad address");
  cover property ($rose(readyBusyFlag) && cmdSeen_ff == CMD_ERASE);
  cover property ($fell(progPulseN) && cmdSeen_ff == CMD_WR_EE);
  cover property (devDataOe && cmdSeen_ff == CMD_RD_SIG && byteSelectA);
endmodule : ppp_props
`default_nettype wire

// ==== parallel_nvm_program_port_tb.sv ====
/* bench: programmer and device joined by ppp_if, run through the
   host register port. assumes shortened busy counts. */
`timescale 1ns/1ps
`default_nettype none
module parallel_nvm_program_port_tb
  import ppp_pkg::*;
;
  localparam logic [23:0] SIGS = 24'h21C36B; // arbitrary value
  localparam logic [7:0] CAL = 8'h9D; // arbitrary value
  localparam logic [23:0] FRST = 24'hF9DFE2;
  localparam logic [5:0] PSEL = 6'h24;
  localparam logic [5:0] RSEL = 6'h2C;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  int miscompares = 0;
  int checks_done = 0;
  int i;
  logic [7:0] got, b, lk;
  logic [15:0] w, st;
  logic [23:0] fz;
  logic [31:0] ee, lkd;
  always #50 clock = ~clock;
  ppp_if pins ();
  ppp_device #(.WR_BUSY_CYC(40), .CE_BUSY_CYC(100), .SIG0(SIGS[7:0]),
    .SIG1(SIGS[15:8]), .SIG2(SIGS[23:16]), .CALIB(CAL),
    .FUSE_LO_RST(FRST[7:0]), .FUSE_HI_RST(FRST[15:8]),
    .FUSE_EX_RST(FRST[23:16])) u_ppp_device (.clock(clock),
    .nrst(nrst), .pins(pins));
  ppp_host u_ppp_host (.clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pins(pins));
  ppp_props #(.WR_BUSY_CYC(40), .CE_BUSY_CYC(100)) u_props (.clock(clock),
    .nrst(nrst), .actionSelect(pins.actionSelect),
    .byteSelectA(pins.byteSelectA), .loadStrobeClock(pins.loadStrobeClock),
    .progPulseN(pins.progPulseN), .outputEnableN(pins.outputEnableN),
    .readyBusyFlag(pins.readyBusyFlag), .hostDataOe(pins.hostDataOe),
    .devDataOe(pins.devDataOe), .dataBus(pins.dataBus));
  // ------------------------------------------------------------
  // bus cycles, pin actions, compare
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic op(input logic [11:0] p, input logic [1:0] o);
    int n;
    logic [15:0] s;
    wr(HREG_PINS, {4'h0, p});
    wr(HREG_GO, {14'h0000, o});
    for (n = 0; n < 20000; n++) begin
      rd(HREG_STAT, s);
      if (s[0] === 1'b0 && s[1] === 1'b1) break;
    end
    if (n == 20000) begin
      miscompares++;
      end_of_test();
    end
  endtask : op
  task automatic ld(input logic [1:0] a, input logic s, input logic [7:0] d);
    op({1'b0, s, a, d}, OP_LOAD);
  endtask : ld
  task automatic rb(input logic [1:0] bs, output logic [7:0] d);
    logic [15:0] r;
    op({bs, ACT_IDLE, 8'h00}, OP_READ);
    rd(HREG_RDATA, r);
    d = r[7:0];
  endtask : rb
  task automatic prog(input logic [1:0] bs);
    op({bs, ACT_IDLE, 8'h00}, OP_PROG);
  endtask : prog
  function automatic logic [7:0] lockNext(input logic [7:0] o,
                                          input logic [7:0] d);
    lockNext = (o[1:0] == 2'b00) ? ((o & d) | (o & 8'h3C)) : (o & d);
  endfunction : lockNext
  initial begin
    void'($urandom(32'h53D1));
    fz = 24'($urandom);
    ee = $urandom;
    w = 16'($urandom);
    b = 8'($urandom);
    lkd = {8'h00, 8'hFC, 8'hFF, 8'h17 | 8'($urandom)};
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    ld(ACT_CMD, 1'b0, CMD_RD_SIG);
    for (i = 0; i < 4; i++) begin
      ld(ACT_ADDR, 1'b0, 8'(i));
      rb(2'b00, got);
      chk8("signature", (i < 3) ? SIGS[8*i +: 8] : ERASED, got);
    end
    ld(ACT_ADDR, 1'b0, 8'h00);
    rb(2'b01, got);
    chk8("calibration", CAL, got);
    ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
    for (i = 0; i < 3; i++) begin
      rb(RSEL[2*i +: 2], got);
      chk8("fuse reset", FRST[8*i +: 8], got);
    end
    ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
    for (i = 0; i < 3; i++) begin
      ld(ACT_DATA, 1'b0, fz[8*i +: 8]);
      prog(PSEL[2*i +: 2]);
    end
    ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
    for (i = 0; i < 3; i++) begin
      rb(RSEL[2*i +: 2], got);
      chk8("fuse byte", fz[8*i +: 8], got);
    end
    ld(ACT_CMD, 1'b0, CMD_WR_EE);
    ld(ACT_ADDR, 1'b1, {7'h00, w[8]});
    for (i = 0; i < 4; i++) begin
      ld(ACT_ADDR, 1'b0, {b[7:2], 2'(i)});
      ld(ACT_DATA, 1'b0, ee[8*i +: 8]);
      op({2'b00, ACT_IDLE, 8'h00}, OP_LATCH);
    end
    prog(2'b00);
    ld(ACT_CMD, 1'b0, CMD_RD_EE);
    for (i = 0; i < 4; i++) begin
      ld(ACT_ADDR, 1'b0, {b[7:2], 2'(i)});
      rb(2'b00, got);
      chk8("eeprom byte", ee[8*i +: 8], got);
    end
    ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
    ld(ACT_ADDR, 1'b1, {3'h0, ee[4:0]});
    ld(ACT_ADDR, 1'b0, b);
    ld(ACT_DATA, 1'b0, w[7:0]);
    ld(ACT_DATA, 1'b1, w[15:8]);
    wr(HREG_PINS, {4'h0, 2'b00, ACT_IDLE, 8'h00});
    wr(HREG_GO, {14'h0000, OP_PROG});
    wr(HREG_GO, {14'h0000, OP_LOAD});
    rd(HREG_STAT, st);
    chk8("status in busy", 8'h05, st[7:0]);
    rb(2'b00, got);
    chk8("read in busy", ERASED, got);
    ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
    ld(ACT_ADDR, 1'b1, {3'h0, ee[4:0]});
    ld(ACT_ADDR, 1'b0, b);
    rb(2'b00, got);
    chk8("flash low", w[7:0], got);
    rb(2'b01, got);
    chk8("flash high", w[15:8], got);
    lk = LOCK_RST;
    for (i = 0; i < 4; i++) begin
      ld(ACT_CMD, 1'b0, CMD_WR_LOCK);
      ld(ACT_DATA, 1'b0, lkd[8*i +: 8]);
      prog(2'b00);
      lk = lockNext(lk, lkd[8*i +: 8]);
      ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
      rb(2'b01, got);
      chk8("lock bits", lk, got);
    end
    ld(ACT_CMD, 1'b0, CMD_ERASE);
    prog(2'b00);
    ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rb(2'b01, got);
    chk8("lock after erase", LOCK_RST, got);
    rb(2'b00, got);
    chk8("fuse after erase", fz[7:0], got);
    ld(ACT_CMD, 1'b0, CMD_RD_EE);
    rb(2'b00, got);
    chk8("eeprom after erase", ERASED, got);
    end_of_test();
  end
endmodule : parallel_nvm_program_port_tb
`default_nettype wire
